/* File: include/scan_map_pkg.sv */
// Behaviour
// - Data pointer write loads four area pointers
// - Data pointers advance per long word written, the scan-in pointer per long word read
// - Buffer address is area base plus pointer
// - Signature values split low and high halves
// - Vector descriptors at 0x700, upper bytes ignored
// - Vector descriptor field layout given as package constants
// - Header/trailer entries at 0x708 to 0x787
// - Seed halves writable at 08h and 09h
// - Result halves readable at 0Ah and 0Bh
// - Exponent register at 07h, three bits
// - Bridge pointer at 19h, base 0x7B8
// - Buffer 2048 by 32 with two ports
// - Long words stored big-endian in buffer
`default_nettype none
package scan_map_pkg;
  localparam logic [4:0] ADDR_START     = 5'h00;
  localparam logic [4:0] ADDR_STATE     = 5'h01;
  localparam logic [4:0] ADDR_INT_EN    = 5'h02;
  localparam logic [4:0] ADDR_INT_EV    = 5'h03;
  localparam logic [4:0] ADDR_SETUP     = 5'h04;
  localparam logic [4:0] ADDR_SCAN_CLOCK_DIVIDER    = 5'h05;
  localparam logic [4:0] ADDR_EXP       = 5'h07;
  localparam logic [4:0] ADDR_SEED_LO   = 5'h08;
  localparam logic [4:0] ADDR_SEED_HI   = 5'h09;
  localparam logic [4:0] ADDR_RES_LO    = 5'h0a;
  localparam logic [4:0] ADDR_RES_HI    = 5'h0b;
  localparam logic [4:0] ADDR_DATA_PTR  = 5'h0c;
  localparam logic [4:0] ADDR_WIN_OUT   = 5'h0d;
  localparam logic [4:0] ADDR_WIN_IN    = 5'h0e;
  localparam logic [4:0] ADDR_WIN_EXP   = 5'h0f;
  localparam logic [4:0] ADDR_WIN_MASK  = 5'h10;
  localparam logic [4:0] ADDR_VEC_PTR   = 5'h11;
  localparam logic [4:0] ADDR_WIN_VEC   = 5'h12;
  localparam logic [4:0] ADDR_HT_PTR    = 5'h13;
  localparam logic [4:0] ADDR_WIN_HT    = 5'h14;
  localparam logic [4:0] ADDR_MAC_PTR   = 5'h15;
  localparam logic [4:0] ADDR_WIN_MAC   = 5'h16;
  localparam logic [4:0] ADDR_SEQ_PTR   = 5'h17;
  localparam logic [4:0] ADDR_WIN_SEQ   = 5'h18;
  localparam logic [4:0] ADDR_BR_PTR    = 5'h19;
  localparam logic [4:0] ADDR_WIN_BR    = 5'h1a;

  localparam logic [10:0] BASE_OUT  = 11'h000;
  localparam logic [10:0] BASE_IN   = 11'h1c0;
  localparam logic [10:0] BASE_EXP  = 11'h380;
  localparam logic [10:0] BASE_MASK = 11'h540;
  localparam logic [10:0] BASE_VEC  = 11'h700;
  localparam logic [10:0] BASE_HT   = 11'h708;
  localparam logic [10:0] BASE_MAC  = 11'h788;
  localparam logic [10:0] BASE_SEQ  = 11'h798;
  localparam logic [10:0] BASE_BR   = 11'h7b8;

  localparam logic [15:0] RST_ZERO  = 16'h0000;
  localparam logic [15:0] RST_SETUP = 16'h0043;
  localparam logic [15:0] EXP_MASK  = 16'h0007;

  localparam int VEC_LEN_LSB  = 0;
  localparam int VEC_MAC_LSB  = 32;
  localparam int VEC_MAC_W    = 8;
  localparam int VEC_OTF_BIT  = 47;
  localparam int VEC_PAD_LSB  = 48;
  localparam int HT_PAD_LSB   = 0;

  localparam int BUF_DEPTH = 2048;
  localparam int BUF_AW    = 11;
  localparam int NUM_PTR   = 9;
  localparam int ACK_DLY   = 2;
endpackage
`default_nettype wire

/* File: logic/scan_master_register_map.sv */
`timescale 1ns/1ns
`default_nettype none
module scan_master_register_map
  import scan_map_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              host_stb_i,
  input  wire logic              host_wr_i,
  input  wire logic [4:0]        host_addr_i,
  input  wire logic [DW-1:0]     host_wdata_i,
  output logic      [DW-1:0]     host_rdata_o,
  output logic                   host_ack_o,
  input  wire logic [BUF_AW-1:0] eng_addr_i,
  input  wire logic              eng_we_i,
  input  wire logic [31:0]       eng_wdata_i,
  output logic      [31:0]       eng_rdata_o,
  input  wire logic [15:0]       eng_result_lo_i,
  input  wire logic [15:0]       eng_result_hi_i,
  input  wire logic              eng_result_we_i,
  output logic      [15:0]       start_control_o,
  output logic      [15:0]       operating_setup_o,
  output logic      [15:0]       scan_clock_divider_o,
  output logic      [2:0]        signature_exponent_o,
  output logic      [31:0]       signature_seed_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_ACK  = 2'b11
  } host_state_t;

  host_state_t state;
  logic [31:0] buffer [BUF_DEPTH];
  logic [15:0] start_control;
  logic [15:0] device_state_flags;
  logic [15:0] interrupt_enable_mask;
  logic [15:0] interrupt_event_flags;
  logic [15:0] operating_setup;
  logic [15:0] scan_clock_divider;
  logic [15:0] signature_exponent;
  logic [15:0] signature_seed_low;
  logic [15:0] signature_seed_high;
  logic [15:0] signature_result_low;
  logic [15:0] signature_result_high;
  logic [15:0] data_area_pointer;
  logic [15:0] ptr [NUM_PTR];
  logic [15:0] hold_half;
  logic        second_half;
  logic [4:0]  acc_addr;
  logic        acc_wr;
  logic [15:0] acc_wdata;
  logic [31:0] rd_word;
  logic        stb_q;

  logic        take;
  logic        is_win;
  logic [3:0]  win_sel;
  logic [10:0] win_base;
  logic [10:0] buf_addr;
  logic        win_done;
  logic [31:0] next_word;
  logic [15:0] win_ptr;
  logic [15:0] result_high_snap;
  logic        result_pair_open;

  assign take = host_stb_i && !stb_q && state == ST_IDLE;

  // Window selector: index into ptr array, or 15 for a plain register
  always_comb begin
    win_sel  = 4'hf;
    win_base = BASE_OUT;
    if (acc_addr == ADDR_WIN_OUT) begin
      win_sel  = 4'd0;
      win_base = BASE_OUT;
    end else if (acc_addr == ADDR_WIN_IN) begin
      win_sel  = 4'd1;
      win_base = BASE_IN;
    end else if (acc_addr == ADDR_WIN_EXP) begin
      win_sel  = 4'd2;
      win_base = BASE_EXP;
    end else if (acc_addr == ADDR_WIN_MASK) begin
      win_sel  = 4'd3;
      win_base = BASE_MASK;
    end else if (acc_addr == ADDR_WIN_VEC) begin
      win_sel  = 4'd4;
      win_base = BASE_VEC;
    end else if (acc_addr == ADDR_WIN_HT) begin
      win_sel  = 4'd5;
      win_base = BASE_HT;
    end else if (acc_addr == ADDR_WIN_MAC) begin
      win_sel  = 4'd6;
      win_base = BASE_MAC;
    end else if (acc_addr == ADDR_WIN_SEQ) begin
      win_sel  = 4'd7;
      win_base = BASE_SEQ;
    end else if (acc_addr == ADDR_WIN_BR) begin
      win_sel  = 4'd8;
      win_base = BASE_BR;
    end
  end

  // Pointer of the selected area; plain register accesses leave it unused
  always_comb begin
    win_ptr = ptr[0];
    for (int j = 1; j < NUM_PTR; j++) begin
      if (win_sel == 4'(j)) begin
        win_ptr = ptr[j];
      end
    end
  end

  assign is_win   = win_sel != 4'hf;
  assign buf_addr = win_base + win_ptr[10:0];
  assign win_done = is_win && second_half && state == ST_READ;
  // First half carries the high bytes, so the word lands big-endian
  assign next_word = {hold_half, acc_wdata};

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stb_q <= 1'b0;
    end else begin
      stb_q <= host_stb_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state     <= ST_IDLE;
      acc_addr  <= 5'h00;
      acc_wr    <= 1'b0;
      acc_wdata <= RST_ZERO;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take) begin
            acc_addr  <= host_addr_i;
            acc_wr    <= host_wr_i;
            acc_wdata <= host_wdata_i;
            state     <= ST_READ;
          end
        end
        ST_READ: begin
          state <= ST_ACK;
        end
        ST_ACK: begin
          if (!host_stb_i) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign host_ack_o = state == ST_ACK;

  // Half-word tracker shared by all windows; any register access resyncs it
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      second_half <= 1'b0;
      hold_half   <= RST_ZERO;
    end else if (state == ST_READ) begin
      if (!is_win) begin
        second_half <= 1'b0;
      end else begin
        second_half <= !second_half;
        if (!second_half && acc_wr) begin
          hold_half <= acc_wdata;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (win_done && acc_wr) begin
      buffer[buf_addr] <= next_word;
    end
    if (eng_we_i) begin
      buffer[eng_addr_i] <= eng_wdata_i;
    end
    eng_rdata_o <= buffer[eng_addr_i];
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_word <= 32'h0000_0000;
    end else if (state == ST_READ && is_win && !second_half) begin
      rd_word <= buffer[buf_addr];
    end
  end

  // Pointers: index writes load them; completed long words advance them, scan-in on reads only, other data areas on writes only
  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        ptr[i] <= RST_ZERO;
      end else if (state == ST_READ && acc_wr && i < 4 && acc_addr == ADDR_DATA_PTR) begin
        ptr[i] <= acc_wdata;
      end else if (state == ST_READ && acc_wr && i == 4 && acc_addr == ADDR_VEC_PTR) begin
        ptr[i] <= acc_wdata;
      end else if (state == ST_READ && acc_wr && i == 5 && acc_addr == ADDR_HT_PTR) begin
        ptr[i] <= acc_wdata;
      end else if (state == ST_READ && acc_wr && i == 6 && acc_addr == ADDR_MAC_PTR) begin
        ptr[i] <= acc_wdata;
      end else if (state == ST_READ && acc_wr && i == 7 && acc_addr == ADDR_SEQ_PTR) begin
        ptr[i] <= acc_wdata;
      end else if (state == ST_READ && acc_wr && i == 8 && acc_addr == ADDR_BR_PTR) begin
        ptr[i] <= acc_wdata;
      end else if (win_done && win_sel == 4'(i)) begin
        if (i == 1 && !acc_wr) begin
          ptr[i] <= ptr[i] + 16'h0001;
        end else if (i != 1 && i < 4 && acc_wr) begin
          ptr[i] <= ptr[i] + 16'h0001;
        end else if (i >= 4) begin
          ptr[i] <= ptr[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      start_control         <= RST_ZERO;
      device_state_flags    <= RST_ZERO;
      interrupt_enable_mask <= RST_ZERO;
      interrupt_event_flags <= RST_ZERO;
      operating_setup       <= RST_SETUP;
      scan_clock_divider    <= RST_ZERO;
      signature_exponent    <= RST_ZERO;
      signature_seed_low    <= RST_ZERO;
      signature_seed_high   <= RST_ZERO;
      data_area_pointer     <= RST_ZERO;
    end else if (state == ST_READ && acc_wr) begin
      if (acc_addr == ADDR_START) begin
        start_control <= acc_wdata;
      end else if (acc_addr == ADDR_STATE) begin
        device_state_flags <= acc_wdata;
      end else if (acc_addr == ADDR_INT_EN) begin
        interrupt_enable_mask <= acc_wdata;
      end else if (acc_addr == ADDR_INT_EV) begin
        interrupt_event_flags <= acc_wdata;
      end else if (acc_addr == ADDR_SETUP) begin
        operating_setup <= acc_wdata;
      end else if (acc_addr == ADDR_SCAN_CLOCK_DIVIDER) begin
        scan_clock_divider <= acc_wdata;
      end else if (acc_addr == ADDR_EXP) begin
        signature_exponent <= acc_wdata & EXP_MASK;
      end else if (acc_addr == ADDR_SEED_LO) begin
        signature_seed_low <= acc_wdata;
      end else if (acc_addr == ADDR_SEED_HI) begin
        signature_seed_high <= acc_wdata;
      end else if (acc_addr == ADDR_DATA_PTR) begin
        data_area_pointer <= acc_wdata;
      end
    end
  end

  // Result halves: engine update takes priority over a host write
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      signature_result_low  <= RST_ZERO;
      signature_result_high <= RST_ZERO;
    end else if (eng_result_we_i) begin
      signature_result_low  <= eng_result_lo_i;
      signature_result_high <= eng_result_hi_i;
    end else if (state == ST_READ && acc_wr && acc_addr == ADDR_RES_LO) begin
      signature_result_low <= acc_wdata;
    end else if (state == ST_READ && acc_wr && acc_addr == ADDR_RES_HI) begin
      signature_result_high <= acc_wdata;
    end
  end

  // Reading the low result half freezes the high half, so an engine
  // update between the two host reads cannot tear the pair
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_pair_open <= 1'b0;
      result_high_snap <= RST_ZERO;
    end else if (state == ST_READ) begin
      result_pair_open <= !acc_wr && acc_addr == ADDR_RES_LO;
      if (!acc_wr && acc_addr == ADDR_RES_LO) begin
        result_high_snap <= signature_result_high;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      host_rdata_o <= RST_ZERO;
    end else if (state == ST_READ && !acc_wr) begin
      if (is_win && !second_half) begin
        host_rdata_o <= buffer[buf_addr][31:16];
      end else if (is_win) begin
        host_rdata_o <= rd_word[15:0];
      end else if (acc_addr == ADDR_START) begin
        host_rdata_o <= start_control;
      end else if (acc_addr == ADDR_STATE) begin
        host_rdata_o <= device_state_flags;
      end else if (acc_addr == ADDR_INT_EN) begin
        host_rdata_o <= interrupt_enable_mask;
      end else if (acc_addr == ADDR_INT_EV) begin
        host_rdata_o <= interrupt_event_flags;
      end else if (acc_addr == ADDR_SETUP) begin
        host_rdata_o <= operating_setup;
      end else if (acc_addr == ADDR_SCAN_CLOCK_DIVIDER) begin
        host_rdata_o <= scan_clock_divider;
      end else if (acc_addr == ADDR_EXP) begin
        host_rdata_o <= signature_exponent;
      end else if (acc_addr == ADDR_SEED_LO) begin
        host_rdata_o <= signature_seed_low;
      end else if (acc_addr == ADDR_SEED_HI) begin
        host_rdata_o <= signature_seed_high;
      end else if (acc_addr == ADDR_RES_LO) begin
        host_rdata_o <= signature_result_low;
      end else if (acc_addr == ADDR_RES_HI) begin
        host_rdata_o <= result_pair_open ? result_high_snap : signature_result_high;
      end else if (acc_addr == ADDR_DATA_PTR) begin
        host_rdata_o <= data_area_pointer;
      end else if (acc_addr == ADDR_VEC_PTR) begin
        host_rdata_o <= ptr[4];
      end else if (acc_addr == ADDR_HT_PTR) begin
        host_rdata_o <= ptr[5];
      end else if (acc_addr == ADDR_MAC_PTR) begin
        host_rdata_o <= ptr[6];
      end else if (acc_addr == ADDR_SEQ_PTR) begin
        host_rdata_o <= ptr[7];
      end else if (acc_addr == ADDR_BR_PTR) begin
        host_rdata_o <= ptr[8];
      end else begin
        host_rdata_o <= RST_ZERO;
      end
    end
  end

  assign start_control_o      = start_control;
  assign operating_setup_o    = operating_setup;
  assign scan_clock_divider_o = scan_clock_divider;
  assign signature_exponent_o = signature_exponent[2:0];
  assign signature_seed_o     = {signature_seed_high, signature_seed_low};

endmodule
`default_nettype wire

/* File: dv/scan_map_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module scan_map_chk
  import scan_map_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic          ref_clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          host_stb_i,
  input  wire logic          host_wr_i,
  input  wire logic [4:0]    host_addr_i,
  input  wire logic [DW-1:0] host_wdata_i,
  input  wire logic [DW-1:0] host_rdata_o,
  input  wire logic          host_ack_o,
  input  wire logic [2:0]    signature_exponent_o,
  input  wire logic [31:0]   signature_seed_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_ack_bound; $rose(host_stb_i) |-> ##[1:4] host_ack_o; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("ack missing after strobe");
  property p_ack_early; $rose(host_stb_i) |-> !host_ack_o ##1 !host_ack_o; endproperty
  a_ack_early: assert property (p_ack_early) else $error("ack too early");
  property p_ack_hold; host_ack_o && host_stb_i |=> host_ack_o; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped under strobe");
  property p_ack_drop; $fell(host_stb_i) |-> ##[1:2] !host_ack_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held after strobe");
  property p_idle; !host_stb_i && !host_ack_o |=> !host_ack_o; endproperty
  a_idle: assert property (p_idle) else $error("ack without strobe");
  property p_rdata; host_ack_o && $past(host_ack_o) |-> $stable(host_rdata_o); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved under ack");
  property p_exp;
    $rose(host_ack_o) && host_wr_i && host_addr_i == ADDR_EXP |-> signature_exponent_o == host_wdata_i[2:0];
  endproperty
  a_exp: assert property (p_exp) else $error("exponent not loaded");
  property p_seed_lo;
    $rose(host_ack_o) && host_wr_i && host_addr_i == ADDR_SEED_LO |-> signature_seed_o[15:0] == host_wdata_i;
  endproperty
  a_seed_lo: assert property (p_seed_lo) else $error("seed low not loaded");
  property p_seed_hi;
    $rose(host_ack_o) && host_wr_i && host_addr_i == ADDR_SEED_HI |-> signature_seed_o[31:16] == host_wdata_i;
  endproperty
  a_seed_hi: assert property (p_seed_hi) else $error("seed high not loaded");
endmodule
`default_nettype wire

/* File: dv/scan_engine_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Second buffer port; writes the scan-in area, which host writes through the scan-in window can also reach
module scan_engine_model
  import scan_map_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic [31:0]       eng_rdata_i,
  output logic      [BUF_AW-1:0] eng_addr_o,
  output logic                   eng_we_o,
  output logic      [31:0]       eng_wdata_o,
  output logic      [15:0]       res_lo_o,
  output logic      [15:0]       res_hi_o,
  output logic                   res_we_o
);
  initial begin
    eng_addr_o = '0;
    eng_we_o = 1'b0;
    eng_wdata_o = '0;
    res_lo_o = '0;
    res_hi_o = '0;
    res_we_o = 1'b0;
  end
  task automatic put(input logic [BUF_AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    eng_addr_o <= a;
    eng_we_o <= 1'b1;
    eng_wdata_o <= d;
    @(posedge ref_clk_i);
    eng_we_o <= 1'b0;
    eng_wdata_o <= ~d;
  endtask
  task automatic get(input logic [BUF_AW-1:0] a, output logic [31:0] q);
    @(posedge ref_clk_i);
    eng_addr_o <= a;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    q = eng_rdata_i;
  endtask
  task automatic result(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge ref_clk_i);
    res_lo_o <= lo;
    res_hi_o <= hi;
    res_we_o <= 1'b1;
    @(posedge ref_clk_i);
    res_we_o <= 1'b0;
    res_lo_o <= ~lo;
    res_hi_o <= ~hi;
  endtask
endmodule
`default_nettype wire

/* File: dv/scan_master_register_map_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module scan_master_register_map_bench
  import scan_map_pkg::*;
;
  localparam logic [4:0] REGS [17] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h09,
                                       5'h0a, 5'h0b, 5'h0c, 5'h11, 5'h13, 5'h15, 5'h17, 5'h19};
  localparam logic [4:0]  DWIN [3] = '{ADDR_WIN_OUT, ADDR_WIN_EXP, ADDR_WIN_MASK};
  localparam logic [10:0] DBAS [3] = '{BASE_OUT, BASE_EXP, BASE_MASK};
  localparam logic [4:0]  PREG [5] = '{ADDR_VEC_PTR, ADDR_HT_PTR, ADDR_MAC_PTR, ADDR_SEQ_PTR, ADDR_BR_PTR};
  localparam logic [4:0]  PWIN [5] = '{ADDR_WIN_VEC, ADDR_WIN_HT, ADDR_WIN_MAC, ADDR_WIN_SEQ, ADDR_WIN_BR};
  localparam logic [10:0] PBAS [5] = '{BASE_VEC, BASE_HT, BASE_MAC, BASE_SEQ, BASE_BR};
  localparam logic [10:0] PIDX [5] = '{11'h006, 11'h020, 11'h00e, 11'h01e, 11'h03e};
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              stb = 1'b0;
  logic              wr = 1'b0;
  logic [4:0]        addr = '0;
  logic [15:0]       wdata = '0;
  logic [15:0]       rdata, q, set_o, ctl_o, div_o, r_lo, r_hi;
  logic              ack, e_we, r_we;
  logic [BUF_AW-1:0] e_addr;
  logic [31:0]       e_wdata, e_rdata, seed_o, w;
  logic [2:0]        exp_o;
  int                err_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  always #2 clk = ~clk;

  scan_master_register_map dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .host_stb_i(stb), .host_wr_i(wr), .host_addr_i(addr),
    .host_wdata_i(wdata), .host_rdata_o(rdata), .host_ack_o(ack), .eng_addr_i(e_addr),
    .eng_we_i(e_we), .eng_wdata_i(e_wdata), .eng_rdata_o(e_rdata), .eng_result_lo_i(r_lo),
    .eng_result_hi_i(r_hi), .eng_result_we_i(r_we), .start_control_o(ctl_o),
    .operating_setup_o(set_o), .scan_clock_divider_o(div_o), .signature_exponent_o(exp_o),
    .signature_seed_o(seed_o));

  scan_engine_model eng (
    .ref_clk_i(clk), .eng_rdata_i(e_rdata), .eng_addr_o(e_addr), .eng_we_o(e_we),
    .eng_wdata_o(e_wdata), .res_lo_o(r_lo), .res_hi_o(r_hi), .res_we_o(r_we));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic acc(input logic w_i, input logic [4:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    stb <= 1'b1;
    wr <= w_i;
    addr <= a;
    wdata <= d;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    chk("ack", {31'h0, ack}, 32'h1);
    q = rdata;
    @(posedge clk);
    stb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wlong(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d[31:16]);
    acc(1'b1, a, d[15:0]);
  endtask

  task automatic rlong(input logic [4:0] a);
    acc(1'b0, a, 16'h0000);
    w[31:16] = q;
    acc(1'b0, a, 16'h0000);
    w[15:0] = q;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      finish_test;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      acc(1'b0, REGS[i], 16'h0000);
      chk("reset value", {16'h0, q}, {16'h0, (REGS[i] == ADDR_SETUP) ? RST_SETUP : RST_ZERO});
    end
    chk("setup out reset", {16'h0, set_o}, {16'h0, RST_SETUP});
    for (int i = 0; i < 17; i++) begin
      acc(1'b1, REGS[i], 16'h00a0 + 16'(i));
      acc(1'b0, REGS[i], 16'h0000);
      chk("readback", {16'h0, q}, (REGS[i] == ADDR_EXP) ? 32'h0000_0006 : 32'h00a0 + 32'(i));
    end
    chk("seed out", seed_o, 32'h00a8_00a7);
    chk("control outs", {ctl_o, div_o}, 32'h00a0_00a5);
    chk("setup out", {16'h0, set_o}, 32'h00a4);
    acc(1'b1, ADDR_EXP, 16'hfffd);
    chk("exponent", {29'h0, exp_o}, 32'h5);
    acc(1'b1, 5'h06, 16'hbeef);
    acc(1'b0, 5'h06, 16'h0000);
    chk("unmapped", {16'h0, q}, 32'h0);
    acc(1'b1, ADDR_DATA_PTR, 16'h01be);
    for (int k = 0; k < 3; k++) begin
      eng.put(DBAS[k] + 11'h1be, 32'h0);
      acc(1'b1, DWIN[k], 16'hc0d0 + 16'(k));
      eng.get(DBAS[k] + 11'h1be, w);
      chk("half word", w, 32'h0);
      acc(1'b1, DWIN[k], 16'h1234);
      eng.get(DBAS[k] + 11'h1be, w);
      chk("window word", w, {16'hc0d0 + 16'(k), 16'h1234});
      wlong(DWIN[k], 32'h89ab_cdef + 32'(k));
      eng.get(DBAS[k] + 11'h1bf, w);
      chk("next word", w, 32'h89ab_cdef + 32'(k));
    end
    eng.put(BASE_IN + 11'h1be, 32'h1357_9bdf);
    eng.put(BASE_IN + 11'h1bf, 32'h2468_ace0);
    rlong(ADDR_WIN_IN);
    chk("scan-in word", w, 32'h1357_9bdf);
    rlong(ADDR_WIN_IN);
    chk("scan-in next", w, 32'h2468_ace0);
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, PREG[k], {5'h0, PIDX[k]});
      wlong(PWIN[k], 32'h0000_0040 + 32'(k));
      eng.get(PBAS[k] + PIDX[k], w);
      chk("area word", w, 32'h0000_0040 + 32'(k));
      acc(1'b0, PREG[k], 16'h0000);
      chk("area step", {16'h0, q}, {21'h0, PIDX[k] + 11'h1});
    end
    eng.result(16'h4321, 16'h8765);
    acc(1'b0, ADDR_RES_LO, 16'h0000);
    chk("result low", {16'h0, q}, 32'h4321);
    acc(1'b0, ADDR_RES_HI, 16'h0000);
    chk("result high", {16'h0, q}, 32'h8765);
    acc(1'b0, ADDR_RES_LO, 16'h0000);
    eng.result(16'h1111, 16'h2222);
    acc(1'b0, ADDR_RES_HI, 16'h0000);
    chk("result pair", {16'h0, q}, 32'h8765);
    acc(1'b0, ADDR_RES_HI, 16'h0000);
    chk("result live", {16'h0, q}, 32'h2222);
    finish_test;
  end
endmodule

bind scan_master_register_map scan_map_chk #(.DW(DW)) chk (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .host_stb_i(host_stb_i), .host_wr_i(host_wr_i),
  .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
  .host_ack_o(host_ack_o), .signature_exponent_o(signature_exponent_o), .signature_seed_o(signature_seed_o));
`default_nettype wire
